/* design/ueb_consts.svh */
// constants for the unbalance event block: timing, depths, ratios
// assumes a 50 MHz clock and a 5 ms program cycle
`ifndef UEB_CONSTS_SVH
`define UEB_CONSTS_SVH

`define UEB_CLK_MHZ         50
`define UEB_CYCLE_US        5000
`define UEB_CYCLE_CLKS      (`UEB_CYCLE_US * `UEB_CLK_MHZ)
`define UEB_CYCLE_MS        5
`define UEB_PRE_TRIG_MS     20
`define UEB_PRE_FAULT_MS    200
`define UEB_PRE_TRIG_TICKS  (`UEB_PRE_TRIG_MS / `UEB_CYCLE_MS)
`define UEB_PRE_FAULT_TICKS (`UEB_PRE_FAULT_MS / `UEB_CYCLE_MS)
`define UEB_HIST_DEPTH      (`UEB_PRE_FAULT_TICKS + 1)
`define UEB_LOG_DEPTH       12
`define UEB_STAGES          4
`define UEB_KINDS           3
`define UEB_K_START         0
`define UEB_K_TRIP          1
`define UEB_K_BLOCK         2
`define UEB_RESET_PCT       32'h0000_0061
`define UEB_FULL_PCT        32'h0000_0064

`endif

/* design/ueb_pkg.sv */
// types shared by the unbalance stage and the event block top
// sizes come from ueb_consts.svh
`include "ueb_consts.svh"
package ueb_pkg;

  typedef enum logic [1:0] {
    UEB_MODE_INST = 2'b00,
    UEB_MODE_DT   = 2'b01,
    UEB_MODE_INV  = 2'b10,
    UEB_MODE_QUAD = 2'b11
  } ueb_mode_e;

  typedef enum logic [1:0] {
    UEB_ST_IDLE    = 2'b00,
    UEB_ST_START   = 2'b01,
    UEB_ST_TRIP    = 2'b10,
    UEB_ST_BLOCKED = 2'b11
  } ueb_state_e;

  typedef struct packed {
    ueb_state_e  state;
    logic        picked;
    logic        releasing;
    logic [31:0] acc;
    logic [31:0] rel_cnt;
    logic [31:0] remaining;
    logic        start;
    logic        trip;
    logic        blocked;
  } ueb_stage_s;

  typedef struct packed {
    logic [1:0]  stage;
    logic [1:0]  kind;
    logic [31:0] stamp;
    logic [15:0] pre_trigger;
    logic [15:0] fault;
    logic [15:0] pre_fault;
    logic [15:0] pos_mag;
    logic [15:0] neg_mag;
    logic [15:0] zero_mag;
    logic [15:0] pos_ang;
    logic [15:0] neg_ang;
    logic [15:0] zero_ang;
    logic [31:0] remaining;
    logic [2:0]  group;
  } ueb_record_s;

  typedef struct packed {
    logic [31:0]                                        div;
    logic                                               tick;
    logic [31:0]                                        stamp;
    logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]             prev;
    logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]             evt_on;
    logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]             evt_off;
    logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]             store_on;
    logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]             store_off;
    logic [31:0]                                        evt_stamp;
    logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0][15:0]       cnt;
    logic [`UEB_STAGES*`UEB_KINDS-1:0]                  pending;
    logic [`UEB_HIST_DEPTH-1:0][15:0]                   hist;
    ueb_record_s [`UEB_LOG_DEPTH-1:0]                   log;
    logic [3:0]                                         wr_ptr;
    logic [3:0]                                         count;
    ueb_record_s                                        rd_rec;
  } ueb_top_s;

endpackage

/* design/ueb_stage.sv */
// one negative_sequence_stage: pick-up with hysteresis, trip and release timing
// assumes tick_i is a one-cycle pulse per program cycle from the same clock
`timescale 1ns/1ps
`include "ueb_consts.svh"
module ueb_stage (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              tick_i,
  input  wire logic              block_i,
  input  wire logic [15:0]       meas_i,
  input  wire logic [15:0]       thr_i,
  input  wire ueb_pkg::ueb_mode_e mode_i,
  input  wire logic [31:0]       delay_i,
  input  wire logic [31:0]       k_i,
  input  wire logic [31:0]       release_i,
  output logic                   start_o,
  output logic                   trip_o,
  output logic                   blocked_o,
  output logic [31:0]            remaining_o
);
  ueb_pkg::ueb_stage_s st;
  ueb_pkg::ueb_stage_s next_st;
  logic        above;
  logic        below;
  logic        pick_n;
  logic [31:0] incr;
  logic [31:0] limit;
  logic [32:0] sum;

  always_comb begin
    next_st = st;
    above = meas_i > thr_i;
    below = ({16'h0000, meas_i} * `UEB_FULL_PCT) < ({16'h0000, thr_i} * `UEB_RESET_PCT); // RULE17
    pick_n = st.picked ? !below : above; // RULE17
    incr = 32'h0000_0000;
    unique case (mode_i)
      ueb_pkg::UEB_MODE_INST: incr = 32'h0000_0000;
      ueb_pkg::UEB_MODE_DT:   incr = 32'h0000_0001; // RULE3
      ueb_pkg::UEB_MODE_INV: begin
        if (above) incr = {16'h0000, 16'(meas_i - thr_i)}; // RULE4 RULE20
      end
      ueb_pkg::UEB_MODE_QUAD: begin
        // integrating m^2-s^2 per cycle until it reaches k avoids a divider
        if (above) incr = {16'h0000, meas_i} * {16'h0000, meas_i} - {16'h0000, thr_i} * {16'h0000, thr_i}; // RULE5 RULE20
      end
    endcase
    limit = (mode_i == ueb_pkg::UEB_MODE_DT) ? delay_i : k_i; // RULE1
    sum = {1'b0, st.acc} + {1'b0, incr};
    if (tick_i) begin // RULE21
      next_st.picked = pick_n;
      unique case (st.state)
        ueb_pkg::UEB_ST_IDLE: begin
          if (pick_n && block_i) begin // RULE18
            next_st.state = ueb_pkg::UEB_ST_BLOCKED;
            next_st.releasing = 1'b0;
            next_st.acc = 32'h0000_0000;
          end else if (pick_n) begin
            next_st.releasing = 1'b0;
            next_st.state = (mode_i == ueb_pkg::UEB_MODE_INST) ? ueb_pkg::UEB_ST_TRIP : ueb_pkg::UEB_ST_START; // RULE2
          end else if (st.releasing) begin // RULE6
            if ({1'b0, st.rel_cnt} + 33'h0_0000_0001 >= {1'b0, release_i}) begin
              next_st.acc = 32'h0000_0000;
              next_st.releasing = 1'b0;
            end else begin
              next_st.rel_cnt = st.rel_cnt + 32'h0000_0001;
            end
          end
        end
        ueb_pkg::UEB_ST_START: begin
          if (!pick_n || block_i) begin // RULE19
            next_st.state = ueb_pkg::UEB_ST_IDLE;
            next_st.rel_cnt = 32'h0000_0000;
            next_st.releasing = (release_i != 32'h0000_0000); // RULE6
            if (release_i == 32'h0000_0000) next_st.acc = 32'h0000_0000;
          end else if (mode_i == ueb_pkg::UEB_MODE_INST || sum >= {1'b0, limit}) begin // RULE3 RULE4
            next_st.state = ueb_pkg::UEB_ST_TRIP;
            next_st.acc = limit;
          end else begin
            next_st.acc = sum[31:0];
          end
        end
        ueb_pkg::UEB_ST_TRIP: begin
          if (!pick_n || block_i) begin
            next_st.state = ueb_pkg::UEB_ST_IDLE;
            next_st.acc = 32'h0000_0000;
          end
        end
        ueb_pkg::UEB_ST_BLOCKED: begin
          if (!pick_n || !block_i) next_st.state = ueb_pkg::UEB_ST_IDLE;
        end
      endcase
    end
    next_st.start = (next_st.state == ueb_pkg::UEB_ST_START) || (next_st.state == ueb_pkg::UEB_ST_TRIP); // RULE2
    next_st.trip = (next_st.state == ueb_pkg::UEB_ST_TRIP);
    next_st.blocked = (next_st.state == ueb_pkg::UEB_ST_BLOCKED);
    next_st.remaining = (next_st.state == ueb_pkg::UEB_ST_START && limit > next_st.acc) ?
                        limit - next_st.acc : 32'h0000_0000;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign start_o = st.start;
  assign trip_o = st.trip;
  assign blocked_o = st.blocked;
  assign remaining_o = st.remaining;

  inst_trip_same_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE2
    tick_i && st.state == ueb_pkg::UEB_ST_IDLE && mode_i == ueb_pkg::UEB_MODE_INST && !block_i && pick_n
    |=> start_o && trip_o) else $error("instant trip not with start");
  blocked_skip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE18
    tick_i && st.state == ueb_pkg::UEB_ST_IDLE && block_i && pick_n
    |=> blocked_o && !start_o && !trip_o && st.acc == 32'h0000_0000) else $error("blocked pick-up not skipped");
  quad_no_advance_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE20
    tick_i && mode_i == ueb_pkg::UEB_MODE_QUAD && !above && st.state == ueb_pkg::UEB_ST_START
    |=> st.acc <= $past(st.acc)) else $error("quadratic curve advanced below threshold");
  pickup_hyst_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE17
    tick_i && st.picked && !below |=> st.picked) else $error("pick-up released above reset ratio");
  block_release_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE19
    tick_i && st.state == ueb_pkg::UEB_ST_START && block_i && release_i != 32'h0000_0000
    |=> !start_o && st.releasing && st.acc == $past(st.acc)) else $error("block after start not released");
  dt_trip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE3
    tick_i && st.state == ueb_pkg::UEB_ST_START && mode_i == ueb_pkg::UEB_MODE_DT && pick_n && !block_i
    && st.acc + 32'h0000_0001 >= delay_i |=> trip_o) else $error("definite delay trip missed");
endmodule // ueb_stage

/* design/ueb_top.sv */
// unbalance_event_block: four stages, events, counters and twelve-entry fault log
// assumes all inputs come from logic on clk_i; measurements update once per program cycle
//
// Summary of operation
// [RULE1] three timing modes: instant, fixed delay, current-dependent delay
// [RULE2] instant mode trips in the same cycle start asserts
// [RULE3] fixed delay trips after configured delay while pick-up holds
// [RULE4] current-dependent delay derives from threshold and measured current
// [RULE5] quadratic curve: time is k over measured squared minus threshold squared
// [RULE6] release timing keeps the timer for a set time after pick-up drops
// [RULE7] on and off events for start, trip and blocked per stage
// [RULE8] per event choice of storing on, off or both
// [RULE9] every event carries a time stamp
// [RULE10] cumulative start, trip and blocked counters, each clearable
// [RULE11] four independent stages with separate events
// [RULE12] rolling log of twelve newest fault records
// [RULE13] records made only on on-transitions of start, trip, blocked
// [RULE14] record holds current at -20 ms, now, and -200 ms
// [RULE15] record holds sequence magnitudes, angles, remaining time, setting group
// [RULE16] stage outputs exposed for direct outputs and user logic
// [RULE17] pick-up releases below ninety-seven percent of threshold
// [RULE18] blocking at pick-up gives blocked status and no timing
// [RULE19] blocking after start drops start and runs release timing
// [RULE20] quadratic curve does not advance when current not above threshold
// [RULE21] evaluation once per five millisecond program cycle
`timescale 1ns/1ps
`include "ueb_consts.svh"
module ueb_top #(
  parameter int unsigned CYCLE_CLKS = `UEB_CYCLE_CLKS
) (
  input  wire logic                                        clk_i,
  input  wire logic                                        rst_b_i,
  input  wire logic [15:0]                                 measured_negative_sequence_i,
  input  wire logic [15:0]                                 pos_mag_i,
  input  wire logic [15:0]                                 zero_sequence_current_i,
  input  wire logic [15:0]                                 pos_ang_i,
  input  wire logic [15:0]                                 neg_ang_i,
  input  wire logic [15:0]                                 zero_ang_i,
  input  wire logic [2:0]                                  group_i,
  input  wire logic [`UEB_STAGES-1:0]                      block_i,
  input  wire logic [`UEB_STAGES-1:0][15:0]                pickup_threshold_i,
  input  wire logic [`UEB_STAGES-1:0][1:0]                 mode_i,
  input  wire logic [`UEB_STAGES-1:0][31:0]                delay_i,
  input  wire logic [`UEB_STAGES-1:0][31:0]                k_i,
  input  wire logic [`UEB_STAGES-1:0][31:0]                release_i,
  input  wire logic [`UEB_KINDS-1:0]                       store_on_i,
  input  wire logic [`UEB_KINDS-1:0]                       store_off_i,
  input  wire logic [`UEB_KINDS-1:0]                       cnt_clear_i,
  input  wire logic [3:0]                                  rd_idx_i,
  output logic [`UEB_STAGES-1:0]                           start_o,
  output logic [`UEB_STAGES-1:0]                           trip_o,
  output logic [`UEB_STAGES-1:0]                           blocked_o,
  output logic [`UEB_STAGES-1:0][31:0]                     remaining_o,
  output logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]           evt_on_o,
  output logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]           evt_off_o,
  output logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]           store_on_o,
  output logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0]           store_off_o,
  output logic [31:0]                                      evt_stamp_o,
  output logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0][15:0]     cnt_o,
  output logic [3:0]                                       log_count_o,
  output ueb_pkg::ueb_record_s                             rec_o
);
  ueb_pkg::ueb_top_s st;
  ueb_pkg::ueb_top_s next_st;
  logic [`UEB_STAGES-1:0][`UEB_KINDS-1:0] cur;

  // each stage keeps its own timers and status
  for (genvar g = 0; g < `UEB_STAGES; g++) begin : g_stage // RULE11
    ueb_stage u_stage (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .tick_i      (st.tick),
      .block_i     (block_i[g]),
      .meas_i      (measured_negative_sequence_i),
      .thr_i       (pickup_threshold_i[g]),
      .mode_i      (ueb_pkg::ueb_mode_e'(mode_i[g])),
      .delay_i     (delay_i[g]),
      .k_i         (k_i[g]),
      .release_i   (release_i[g]),
      .start_o     (start_o[g]),
      .trip_o      (trip_o[g]),
      .blocked_o   (blocked_o[g]),
      .remaining_o (remaining_o[g])
    ); // RULE16
    assign cur[g][`UEB_K_START] = start_o[g];
    assign cur[g][`UEB_K_TRIP] = trip_o[g];
    assign cur[g][`UEB_K_BLOCK] = blocked_o[g];
  end

  always_comb begin
    logic [4:0]  ri;
    logic        found;
    logic [15:0] base;
    ri = 5'h00;
    found = 1'b0;
    base = 16'h0000;
    next_st = st;
    // program cycle divider
    next_st.tick = (st.div == 32'(CYCLE_CLKS - 1)); // RULE21
    next_st.div = next_st.tick ? 32'h0000_0000 : st.div + 32'h0000_0001;
    if (st.tick) begin
      next_st.stamp = st.stamp + 32'h0000_0001;
      next_st.hist = {st.hist[`UEB_HIST_DEPTH-2:0], measured_negative_sequence_i}; // RULE14
    end
    // edge detection; status only moves one cycle after a tick
    next_st.prev = cur;
    if (cur != st.prev) next_st.evt_stamp = st.stamp; // RULE9
    for (int s = 0; s < `UEB_STAGES; s++) begin
      for (int k = 0; k < `UEB_KINDS; k++) begin
        next_st.evt_on[s][k] = cur[s][k] && !st.prev[s][k]; // RULE7
        next_st.evt_off[s][k] = !cur[s][k] && st.prev[s][k]; // RULE7
        next_st.store_on[s][k] = next_st.evt_on[s][k] && store_on_i[k]; // RULE8
        next_st.store_off[s][k] = next_st.evt_off[s][k] && store_off_i[k]; // RULE8
        // a clear and a count in one cycle leave the count at one
        base = cnt_clear_i[k] ? 16'h0000 : st.cnt[s][k]; // RULE10
        next_st.cnt[s][k] = next_st.evt_on[s][k] ? base + 16'h0001 : base; // RULE10
      end
    end
    // one record per clock; a tick is far longer than twelve clocks so none is lost
    for (int i = 0; i < `UEB_STAGES * `UEB_KINDS; i++) begin
      if (!found && st.pending[i]) begin
        found = 1'b1;
        next_st.pending[i] = 1'b0;
        next_st.log[st.wr_ptr].stage = 2'(i / `UEB_KINDS);
        next_st.log[st.wr_ptr].kind = 2'(i % `UEB_KINDS);
        next_st.log[st.wr_ptr].stamp = st.stamp;
        next_st.log[st.wr_ptr].pre_trigger = st.hist[`UEB_PRE_TRIG_TICKS]; // RULE14
        next_st.log[st.wr_ptr].fault = st.hist[0]; // RULE14
        next_st.log[st.wr_ptr].pre_fault = st.hist[`UEB_PRE_FAULT_TICKS]; // RULE14
        next_st.log[st.wr_ptr].pos_mag = pos_mag_i; // RULE15
        next_st.log[st.wr_ptr].neg_mag = measured_negative_sequence_i; // RULE15
        next_st.log[st.wr_ptr].zero_mag = zero_sequence_current_i; // RULE15
        next_st.log[st.wr_ptr].pos_ang = pos_ang_i; // RULE15
        next_st.log[st.wr_ptr].neg_ang = neg_ang_i; // RULE15
        next_st.log[st.wr_ptr].zero_ang = zero_ang_i; // RULE15
        next_st.log[st.wr_ptr].remaining = remaining_o[i / `UEB_KINDS]; // RULE15
        next_st.log[st.wr_ptr].group = group_i; // RULE15
      end
    end
    if (found) begin // RULE12
      next_st.wr_ptr = (st.wr_ptr == 4'(`UEB_LOG_DEPTH - 1)) ? 4'h0 : st.wr_ptr + 4'h1;
      if (st.count != 4'(`UEB_LOG_DEPTH)) next_st.count = st.count + 4'h1;
    end
    // new on-edges are set after servicing so a set wins over the clear
    for (int s = 0; s < `UEB_STAGES; s++) begin
      for (int k = 0; k < `UEB_KINDS; k++) begin
        if (next_st.evt_on[s][k]) next_st.pending[s * `UEB_KINDS + k] = 1'b1; // RULE13
      end
    end
    // read port, index zero is the newest record
    ri = {1'b0, st.wr_ptr} + 5'(`UEB_LOG_DEPTH - 1) - {1'b0, rd_idx_i};
    if (ri >= 5'(`UEB_LOG_DEPTH)) ri = ri - 5'(`UEB_LOG_DEPTH);
    next_st.rd_rec = (rd_idx_i < st.count) ? st.log[ri[3:0]] : '0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign evt_on_o = st.evt_on;
  assign evt_off_o = st.evt_off;
  assign store_on_o = st.store_on;
  assign store_off_o = st.store_off;
  assign evt_stamp_o = st.evt_stamp;
  assign cnt_o = st.cnt;
  assign log_count_o = st.count;
  assign rec_o = st.rd_rec;

  for (genvar g = 0; g < `UEB_STAGES; g++) begin : g_check
    start_on_evt_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE7
      start_o[g] && !st.prev[g][`UEB_K_START] |=> evt_on_o[g][`UEB_K_START] && !evt_off_o[g][`UEB_K_START]
      ##1 !evt_on_o[g][`UEB_K_START]) else $error("start on event missing");
    trip_off_evt_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE7
      !trip_o[g] && st.prev[g][`UEB_K_TRIP] |=> evt_off_o[g][`UEB_K_TRIP]) else $error("trip off event missing");
    evt_stamp_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
      evt_on_o[g][`UEB_K_BLOCK] |-> evt_stamp_o == $past(st.stamp)) else $error("event stamp wrong");
    store_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE8
      evt_off_o[g][`UEB_K_START] |-> store_off_o[g][`UEB_K_START] == $past(store_off_i[`UEB_K_START]))
      else $error("store selection wrong");
    trip_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE10
      trip_o[g] && !st.prev[g][`UEB_K_TRIP] && !cnt_clear_i[`UEB_K_TRIP]
      |=> cnt_o[g][`UEB_K_TRIP] == $past(cnt_o[g][`UEB_K_TRIP]) + 16'h0001) else $error("trip count not advanced");
  end

  log_grow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE12
    st.pending != '0 && st.count < 4'(`UEB_LOG_DEPTH) |=> log_count_o == $past(log_count_o) + 4'h1)
    else $error("log count not advanced");
  log_cap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE12
    log_count_o <= 4'(`UEB_LOG_DEPTH) && st.wr_ptr < 4'(`UEB_LOG_DEPTH)) else $error("log pointer out of range");
  tick_single_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE21
    st.tick |=> !st.tick) else $error("program cycle tick too long");
endmodule // ueb_top

/* verification/ueb_front_model.sv */
// front-end model: sequence currents and blocking matrix for the event block
// assumes the bench sets the wanted negative-sequence level and block mask on clk_i
`timescale 1ns/1ps
module ueb_front_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] lvl_i,
  input  wire logic [3:0]  blk_i,
  output logic      [15:0] neg_o,
  output logic      [15:0] pos_o,
  output logic      [15:0] ang_o,
  output logic      [3:0]  blk_o
);
  // angles turn every clock so a stale capture never looks right
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      neg_o <= 16'h0000;
      pos_o <= 16'h0100;
      ang_o <= 16'h0000;
      blk_o <= 4'h0;
    end else begin
      neg_o <= lvl_i;
      pos_o <= lvl_i + 16'h0100;
      ang_o <= ang_o + 16'h0001;
      blk_o <= blk_i;
    end
  end
endmodule // ueb_front_model

/* verification/tb_top.sv */
// bench for the unbalance event block: status, events, counters, log
// assumes ueb_front_model feeds the sequence currents and blocking
`timescale 1ns/1ps
module tb_top;
  localparam int CYC = 8;
  logic                  clk_i;
  logic                  rst_b_i;
  logic [15:0]           lvl, neg, pos, ang;
  logic [3:0]            blk_set, blk, rd_idx, log_count_o;
  logic [3:0][15:0]      thr;
  logic [3:0][1:0]       mode;
  logic [3:0][31:0]      dly, kk, rel, remaining_o;
  logic [2:0]            s_on, s_off, clr, group;
  logic [3:0]            start_o, trip_o, blocked_o;
  logic [3:0][2:0]       evt_on_o, evt_off_o, store_on_o, store_off_o;
  logic [31:0]           evt_stamp_o, r0;
  logic [3:0][2:0][15:0] cnt_o;
  ueb_pkg::ueb_record_s  rec_o;
  int                    err_total, compares, n;

  ueb_front_model fm (.clk_i(clk_i), .rst_b_i(rst_b_i), .lvl_i(lvl), .blk_i(blk_set), .neg_o(neg),
    .pos_o(pos), .ang_o(ang), .blk_o(blk));
  ueb_top #(.CYCLE_CLKS(CYC)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .measured_negative_sequence_i(neg),
    .pos_mag_i(pos), .zero_sequence_current_i(neg >> 1), .pos_ang_i(ang), .neg_ang_i(~ang),
    .zero_ang_i(ang ^ 16'h5A5A), .group_i(group), .block_i(blk), .pickup_threshold_i(thr), .mode_i(mode),
    .delay_i(dly), .k_i(kk), .release_i(rel), .store_on_i(s_on), .store_off_i(s_off), .cnt_clear_i(clr),
    .rd_idx_i(rd_idx), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .remaining_o(remaining_o),
    .evt_on_o(evt_on_o), .evt_off_o(evt_off_o), .store_on_o(store_on_o), .store_off_o(store_off_o),
    .evt_stamp_o(evt_stamp_o), .cnt_o(cnt_o), .log_count_o(log_count_o), .rec_o(rec_o));

  always #10 clk_i = ~clk_i;

  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // k: 0 start, 1 trip, 2 blocked; bounded so a dead stage cannot hang
  task automatic wt(input int k, input int s, input logic v);
    logic [2:0] st;
    n = 0;
    st = ~{3{v}};
    while (st[k] !== v && n < 300) begin
      @(negedge clk_i);
      n++;
      st = {blocked_o[s], trip_o[s], start_o[s]};
    end
    if (st[k] !== v) begin
      err_total++;
      wrap_up();
    end
  endtask

  task automatic lvl_set(input logic [15:0] v);
    @(posedge clk_i);
    lvl <= v;
  endtask

  initial begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    lvl = 16'h0000;
    blk_set = 4'h0;
    rd_idx = 4'h0;
    thr = {4{16'hFFFF}};
    mode = 8'hC4;
    dly = {32'h0, 32'h0, 32'h3, 32'h0};
    rel = {32'h0, 32'h0, 32'h2, 32'h0};
    kk = {32'h0000_FFFF, 96'h0};
    s_on = 3'h1;
    s_off = 3'h2;
    clr = 3'h0;
    group = 3'h5;
    err_total = 0;
    compares = 0;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // instant stage 0 just above a threshold of 100
    @(posedge clk_i);
    thr[0] <= 16'h0064;
    lvl_set(16'h0065);
    wt(0, 0, 1'b1);
    chk("trip_with_start", trip_o[0], 32'h1);
    chk("others_quiet", {start_o[3:1], blocked_o}, 32'h0);
    @(negedge clk_i);
    chk("evt_on", evt_on_o[0], 32'h3);
    chk("store_on", store_on_o[0], 32'h1);
    repeat (6) @(negedge clk_i);
    chk("log_count", log_count_o, 32'h2);
    chk("rec_kind", {rec_o.stage, rec_o.kind, rec_o.group}, 32'h0D);
    chk("rec_cur", {rec_o.fault, rec_o.pos_mag}, 32'h0065_0165);
    chk("rec_neg", {rec_o.neg_mag, rec_o.zero_mag}, 32'h0065_0032);
    chk("rec_pre", {rec_o.pre_trigger, rec_o.pre_fault}, 32'h0);
    chk("rec_stamp", rec_o.stamp, 32'h1);
    chk("evt_stamp", evt_stamp_o, 32'h1);
    chk("cnt_on", {cnt_o[0][1], cnt_o[0][0]}, 32'h0001_0001);
    // 98 stays inside the hysteresis band, 96 leaves it
    lvl_set(16'h0062);
    repeat (3 * CYC) @(negedge clk_i);
    chk("hold_band", start_o[0], 32'h1);
    lvl_set(16'h0060);
    wt(0, 0, 1'b0);
    @(negedge clk_i);
    chk("evt_off", evt_off_o[0], 32'h3);
    chk("store_off", store_off_o[0], 32'h2);
    @(posedge clk_i);
    thr[0] <= 16'hFFFF;
    // fixed delay of three program cycles on stage 1
    @(posedge clk_i);
    thr[1] <= 16'h0064;
    lvl <= 16'h0065;
    wt(0, 1, 1'b1);
    wt(1, 1, 1'b1);
    chk("dt_delay", n, 3 * CYC);
    lvl_set(16'h0000);
    thr[1] <= 16'hFFFF;
    wt(0, 1, 1'b0);
    // block after one timed cycle; release keeps the timer so re-pick trips one cycle sooner
    @(posedge clk_i);
    thr[1] <= 16'h0064;
    lvl <= 16'h0065;
    wt(0, 1, 1'b1);
    repeat (CYC) @(negedge clk_i);
    @(posedge clk_i);
    blk_set <= 4'h2;
    wt(0, 1, 1'b0);
    chk("blk_drop", {trip_o[1], blocked_o[1]}, 32'h0);
    @(posedge clk_i);
    blk_set <= 4'h0;
    wt(0, 1, 1'b1);
    wt(1, 1, 1'b1);
    chk("rel_resume", n, 2 * CYC);
    lvl_set(16'h0000);
    thr[1] <= 16'hFFFF;
    wt(0, 1, 1'b0);
    // quadratic stage 3: parked in the band, then driven hard
    @(posedge clk_i);
    thr[3] <= 16'h0064;
    lvl <= 16'h0065;
    wt(0, 3, 1'b1);
    lvl_set(16'h0062);
    repeat (CYC + 2) @(negedge clk_i);
    r0 = remaining_o[3];
    repeat (4 * CYC) @(negedge clk_i);
    chk("quad_frozen", remaining_o[3], r0);
    chk("quad_no_trip", trip_o[3], 32'h0);
    lvl_set(16'h0100);
    wt(1, 3, 1'b1);
    chk("quad_time", (n > CYC && n <= 2 * CYC + 1), 32'h1);
    lvl_set(16'h0000);
    thr[3] <= 16'hFFFF;
    wt(0, 3, 1'b0);
    // blocking already active when stage 2 picks up
    @(posedge clk_i);
    blk_set <= 4'h4;
    thr[2] <= 16'h0064;
    lvl <= 16'h0065;
    wt(2, 2, 1'b1);
    repeat (3 * CYC) @(negedge clk_i);
    chk("blk_no_timing", {start_o[2], trip_o[2]}, 32'h0);
    lvl_set(16'h0000);
    thr[2] <= 16'hFFFF;
    blk_set <= 4'h0;
    wt(2, 2, 1'b0);
    // six more instant pickups push the log past twelve entries
    @(posedge clk_i);
    thr[0] <= 16'h0064;
    repeat (6) begin
      lvl_set(16'h0065);
      wt(0, 0, 1'b1);
      lvl_set(16'h0000);
      wt(0, 0, 1'b0);
    end
    repeat (6) @(negedge clk_i);
    chk("log_full", log_count_o, 32'hC);
    chk("cnt_start", cnt_o[0][0], 32'h7);
    @(posedge clk_i);
    rd_idx <= 4'hB;
    repeat (2) @(negedge clk_i);
    chk("oldest", {rec_o.stage, rec_o.kind, rec_o.group}, 32'h5);
    @(posedge clk_i);
    rd_idx <= 4'hC;
    clr <= 3'h7;
    @(posedge clk_i);
    clr <= 3'h0;
    repeat (2) @(negedge clk_i);
    chk("past_end", (rec_o === '0), 32'h1);
    chk("cnt_clear", (cnt_o === '0), 32'h1);
    wrap_up();
  end
endmodule // tb_top
